/* File: rtl/tecs_regs.svh */
`ifndef TECS_REGS_SVH
`define TECS_REGS_SVH
`define TECS_SETUP_ADDR   8'h21
`define TECS_STATUS_ADDR  8'h22
`define TECS_SETUP_RST    8'h00
`define TECS_STATUS_RST   8'h00
`define TECS_ABORT_BIT    7
`define TECS_LATCH_BIT    6
`define TECS_Z_DBL_BIT    5
`define TECS_Z_SGL_BIT    4
`define TECS_Y_DBL_BIT    3
`define TECS_Y_SGL_BIT    2
`define TECS_X_DBL_BIT    1
`define TECS_X_SGL_BIT    0
`define TECS_EA_BIT       7
`define TECS_SEEN_MSB     6
`define TECS_SEEN_LSB     4
`define TECS_DBL_BIT      3
`define TECS_SIGN_MSB     2
`define TECS_SIGN_LSB     0
`endif

/* File: rtl/tecs_pkg.sv */
package tecs_pkg;
  typedef logic [2:0] tecs_axis_t;
  typedef logic [7:0] tecs_byte_t;
  typedef enum logic [2:0] {
    TECS_IDLE = 3'b001,
    TECS_LAT  = 3'b010,
    TECS_WIN  = 3'b100
  } tecs_state_e;
endpackage : tecs_pkg

/* File: rtl/tecs_tap_seq.sv */
`timescale 1ns/1ps
module tecs_tap_seq (
  input  wire logic                i_mclk,
  input  wire logic                i_nrst,
  input  wire logic                i_tick,
  input  wire tecs_pkg::tecs_axis_t i_start,
  input  wire tecs_pkg::tecs_axis_t i_end,
  input  wire tecs_pkg::tecs_axis_t i_neg,
  input  wire logic                i_abort,
  input  wire tecs_pkg::tecs_byte_t i_latency,
  input  wire tecs_pkg::tecs_byte_t i_window,
  output logic                     o_single,
  output logic                     o_double,
  output tecs_pkg::tecs_axis_t     o_axis,
  output tecs_pkg::tecs_axis_t     o_sign
);
  import tecs_pkg::*;

  tecs_state_e state_r;
  tecs_state_e state_nxt;
  tecs_byte_t  cnt_r;
  tecs_byte_t  cnt_nxt;
  logic        lat_start_r;
  logic        lat_start_nxt;

  wire logic start_any = |i_start;
  wire logic end_any   = |i_end;
  wire logic cnt_zero  = (cnt_r == 8'h00);
  // Pulse both began and finished inside latency
  wire logic short_hit = (lat_start_r | start_any) & end_any;
  wire logic tap_first = (state_r == TECS_IDLE) & end_any;
  wire logic tap_second = (state_r == TECS_WIN) & end_any;

  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    lat_start_nxt = lat_start_r;
    unique case (state_r)
      TECS_IDLE: begin
        if (end_any) begin
          state_nxt     = TECS_LAT;
          cnt_nxt       = i_latency;
          lat_start_nxt = 1'b0;
        end
      end
      TECS_LAT: begin
        if (start_any) begin
          lat_start_nxt = 1'b1;
        end
        if (i_abort && short_hit) begin
          state_nxt = TECS_IDLE;
        end else if (i_tick) begin
          // End pulses are ignored here; starts only set lat_start_r and the timer moves
          if (cnt_zero) begin
            state_nxt = TECS_WIN;
            cnt_nxt   = i_window;
          end else begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
      end
      TECS_WIN: begin
        if (end_any) begin
          state_nxt = TECS_IDLE;
        end else if (i_tick) begin
          if (cnt_zero) begin
            state_nxt = TECS_IDLE;
          end else begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r     <= TECS_IDLE;
      cnt_r       <= 8'h00;
      lat_start_r <= 1'b0;
      o_single    <= 1'b0;
      o_double    <= 1'b0;
      o_axis      <= 3'h0;
      o_sign      <= 3'h0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      lat_start_r <= lat_start_nxt;
      o_single    <= tap_first;
      o_double    <= tap_second;
      o_axis      <= i_end;
      o_sign      <= i_neg & i_end;
    end
  end

  sequence s_short_pulse_in_lat;
    (state_r == TECS_LAT) && i_abort && short_hit;
  endsequence

  AST_ABORT_SUSPENDS: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_short_pulse_in_lat |=> (state_r == TECS_IDLE) ##1 !o_double)
    else $error("double tap not suspended by short pulse in latency");

  AST_NO_ABORT_KEEPS: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    ((state_r == TECS_LAT) && !i_abort && !i_tick) |=> (state_r == TECS_LAT))
    else $error("double tap detection dropped while abort is off");

  AST_LAT_IGNORES: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (state_r == TECS_LAT) |=> !o_single && !o_double)
    else $error("tap reported from a pulse during latency");
endmodule : tecs_tap_seq

/* File: rtl/tecs_top.sv */
`timescale 1ns/1ps
`include "tecs_regs.svh"
module tecs_top (
  input  wire logic                 i_mclk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire tecs_pkg::tecs_byte_t i_reg_addr,
  input  wire tecs_pkg::tecs_byte_t i_reg_wdata,
  output tecs_pkg::tecs_byte_t      o_reg_rdata,
  input  wire logic                 i_sample_tick,
  input  wire tecs_pkg::tecs_axis_t i_pulse_start,
  input  wire tecs_pkg::tecs_axis_t i_pulse_end,
  input  wire tecs_pkg::tecs_axis_t i_pulse_neg,
  input  wire tecs_pkg::tecs_byte_t i_tap_latency_time,
  input  wire tecs_pkg::tecs_byte_t i_tap_window_time,
  output logic                      o_tap_irq
);
  import tecs_pkg::*;

  tecs_byte_t setup_r;
  tecs_byte_t setup_nxt;
  logic       ea_r;
  logic       ea_nxt;
  tecs_axis_t seen_r;
  tecs_axis_t seen_nxt;
  logic       dbl_r;
  logic       dbl_nxt;
  tecs_axis_t sign_r;
  tecs_axis_t sign_nxt;
  tecs_byte_t rdata_nxt;

  logic       seq_single;
  logic       seq_double;
  tecs_axis_t seq_axis;
  tecs_axis_t seq_sign;

  // Register decode
  wire logic setup_sel  = (i_reg_addr == `TECS_SETUP_ADDR);
  wire logic status_sel = (i_reg_addr == `TECS_STATUS_ADDR);
  wire logic setup_wr   = i_reg_wr & setup_sel;
  wire logic status_rd  = i_reg_rd & status_sel;

  // Setup fields
  wire logic double_tap_abort = setup_r[`TECS_ABORT_BIT];
  wire logic flag_latch_on    = setup_r[`TECS_LATCH_BIT];
  wire tecs_axis_t single_en = {setup_r[`TECS_Z_SGL_BIT],
                                setup_r[`TECS_Y_SGL_BIT],
                                setup_r[`TECS_X_SGL_BIT]};
  wire tecs_axis_t double_en = {setup_r[`TECS_Z_DBL_BIT],
                                setup_r[`TECS_Y_DBL_BIT],
                                setup_r[`TECS_X_DBL_BIT]};

  // Event qualification by axis and type
  wire tecs_axis_t type_en = seq_double ? double_en : single_en;
  wire tecs_axis_t q_axis  = seq_axis & type_en;
  wire logic       q_evt   = (seq_single | seq_double) & (|q_axis);

  // Held while latched and not being read this cycle
  wire logic frozen = flag_latch_on & ea_r & ~status_rd;

  wire tecs_byte_t status_val = {ea_r, seen_r, dbl_r, sign_r};

  assign setup_nxt = setup_wr ? i_reg_wdata : setup_r;
  assign rdata_nxt = status_sel ? status_val :
                     setup_sel  ? setup_r : 8'h00;

  // A tap arriving in the reading cycle wins over the clear
  always_comb begin
    ea_nxt   = ea_r;
    seen_nxt = seen_r;
    dbl_nxt  = dbl_r;
    sign_nxt = sign_r;
    if (q_evt && !frozen) begin
      ea_nxt   = 1'b1;
      seen_nxt = q_axis;
      dbl_nxt  = seq_double;
      sign_nxt = seq_sign & q_axis;
    end else if (status_rd) begin
      ea_nxt   = 1'b0;
      seen_nxt = 3'h0;
      dbl_nxt  = 1'b0;
      sign_nxt = 3'h0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      setup_r <= `TECS_SETUP_RST;
      ea_r    <= 1'b0;
      seen_r  <= 3'h0;
      dbl_r   <= 1'b0;
      sign_r  <= 3'h0;
    end else begin
      setup_r <= setup_nxt;
      ea_r    <= ea_nxt;
      seen_r  <= seen_nxt;
      dbl_r   <= dbl_nxt;
      sign_r  <= sign_nxt;
    end
  end

  // Read data is captured before the clear takes effect
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_nxt;
    end
  end

  // Request follows the event flag, so a status read with no tap in the same cycle drops it
  assign o_tap_irq = ea_r;

  tecs_tap_seq u_tap_seq (
    .i_mclk    (i_mclk),
    .i_nrst    (i_nrst),
    .i_tick    (i_sample_tick),
    .i_start   (i_pulse_start),
    .i_end     (i_pulse_end),
    .i_neg     (i_pulse_neg),
    .i_abort   (double_tap_abort),
    .i_latency (i_tap_latency_time),
    .i_window  (i_tap_window_time),
    .o_single  (seq_single),
    .o_double  (seq_double),
    .o_axis    (seq_axis),
    .o_sign    (seq_sign)
  );

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_plain_read;
    status_rd && !q_evt;
  endsequence

  AST_READ_CLEARS: assert property (
    s_plain_read |=> (ea_r == 1'b0) && (seen_r == 3'h0) && !dbl_r && (sign_r == 3'h0))
    else $error("status read did not clear the status bits");

  AST_READ_DROPS_IRQ: assert property (
    s_plain_read |=> !o_tap_irq ##1 (o_tap_irq == $past(q_evt)))
    else $error("interrupt request not dropped by status read");

  AST_EVENT_SETS_EA: assert property (
    q_evt |=> ea_r && o_tap_irq)
    else $error("qualified tap did not set the event flag");

  AST_LATCH_FREEZE: assert property (
    (flag_latch_on && ea_r && !status_rd)
      |=> $stable(seen_r) && $stable(dbl_r) && $stable(sign_r) && ea_r)
    else $error("latched status changed before read");

  AST_ONLY_ENABLED: assert property (
    (q_evt && !frozen) |=> ((seen_r & ~$past(type_en)) == 3'h0))
    else $error("status shows a tap on a disabled axis");

  AST_TYPE_BIT: assert property (
    (q_evt && !frozen) |=> (dbl_r == $past(seq_double)))
    else $error("single or double type bit wrong");

  AST_SIGN_WITH_AXIS: assert property (
    (q_evt && !frozen) |=> (sign_r == ($past(seq_sign) & seen_r)))
    else $error("tap sign does not match triggering pulse");

  AST_FOLLOW_LATEST: assert property (
    (!flag_latch_on && q_evt) |=> (seen_r == $past(q_axis)))
    else $error("unlatched status did not follow latest tap");

  AST_SETUP_WRITE: assert property (
    setup_wr |=> (setup_r == $past(i_reg_wdata)) ##1 (setup_r == $past(setup_nxt)))
    else $error("setup register write not stored");

  AST_RESET_CLEAR: assert property (
    $rose(i_nrst) |-> (status_val == `TECS_STATUS_RST))
    else $error("status not zero after reset");

  AST_RDATA_STATUS: assert property (
    status_rd |=> (o_reg_rdata == $past(status_val)))
    else $error("status read did not return the value before clearing");

  AST_RDATA_SETUP: assert property (
    (i_reg_rd && setup_sel) |=> (o_reg_rdata == $past(setup_r)))
    else $error("setup read returned wrong data");

  AST_RDATA_HOLD: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data changed without a read");

  AST_SETUP_HOLD: assert property (
    !setup_wr |=> $stable(setup_r))
    else $error("setup register changed without a write");

  AST_EA_HOLDS: assert property (
    (ea_r && !status_rd) |=> ea_r)
    else $error("event flag dropped without a status read");

  AST_QUIET_WITHOUT_EA: assert property (
    !ea_r |-> (status_val == 8'h00))
    else $error("status bits set while no event is active");

  AST_SIGN_ONLY_SEEN: assert property (
    (sign_r & ~seen_r) == 3'h0)
    else $error("sign bit set on an axis without an event");

  AST_SINGLE_OFF_SILENT: assert property (
    (seq_single && ((seq_axis & single_en) == 3'h0) && !status_rd) |=> $stable(status_val))
    else $error("single tap reported with its enables off");

  AST_DOUBLE_OFF_SILENT: assert property (
    (seq_double && ((seq_axis & double_en) == 3'h0) && !status_rd) |=> $stable(status_val))
    else $error("double tap reported with its enables off");

  AST_DOUBLE_SETS_BIT: assert property (
    (seq_double && (|q_axis) && !frozen) |=> dbl_r)
    else $error("double tap did not set the type bit");

  AST_SINGLE_CLEARS_BIT: assert property (
    (seq_single && (|q_axis) && !frozen) |=> !dbl_r)
    else $error("single tap left the type bit set");

  sequence s_latch_capture;
    flag_latch_on && q_evt && !frozen;
  endsequence

  AST_CAPTURE_THEN_HOLD: assert property (
    s_latch_capture ##1 (flag_latch_on && !status_rd) |=> $stable(seen_r) && $stable(sign_r))
    else $error("latched tap status not held after capture");
endmodule : tecs_top

/* File: test/tecs_host.sv */
`timescale 1ns/1ps
module tecs_host (
  input  wire logic                 i_mclk,
  input  wire tecs_pkg::tecs_byte_t i_rdata,
  output logic                      o_wr,
  output logic                      o_rd,
  output tecs_pkg::tecs_byte_t      o_addr,
  output tecs_pkg::tecs_byte_t      o_wdata
);
  import tecs_pkg::*;
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end
  task automatic wr(input tecs_byte_t a, input tecs_byte_t d);
    @(posedge i_mclk);
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : wr
  // A status read with no tap in the same cycle also clears status and drops the request on the device side
  task automatic rd(input tecs_byte_t a, output tecs_byte_t d);
    @(posedge i_mclk);
    o_rd   <= 1'b1;
    o_addr <= a;
    @(posedge i_mclk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask : rd
endmodule : tecs_host

/* File: test/test_tecs_top.sv */
`timescale 1ns/1ps
`include "tecs_regs.svh"
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module test_tecs_top;
  import tecs_pkg::*;
  logic       clk = 1'b0;
  logic       nrst, wr, rd, irq;
  logic       tick = 1'b0;
  tecs_byte_t addr, wdata, rdata, lat, win, cfg, d;
  tecs_axis_t ps, pe, pn, a, n;
  int         num_errors = 0, checked = 0, cyc = 0, seed, r, i, p;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    tick <= ~tick;
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      conclude();
    end
  end
  tecs_host u_tecs_host (.i_mclk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
    .o_addr(addr), .o_wdata(wdata));
  tecs_top u_tecs_top (.i_mclk(clk), .i_nrst(nrst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sample_tick(tick),
    .i_pulse_start(ps), .i_pulse_end(pe), .i_pulse_neg(pn), .i_tap_latency_time(lat),
    .i_tap_window_time(win), .o_tap_irq(irq));
  function automatic tecs_byte_t exp_st(tecs_axis_t ax, tecs_axis_t ng, tecs_byte_t c,
                                        logic dbl);
    tecs_axis_t rep;
    rep = ax & (dbl ? {c[5], c[3], c[1]} : {c[4], c[2], c[0]});
    return (rep == 3'h0) ? 8'h00 : {1'b1, rep, dbl, ng & rep};
  endfunction : exp_st
  task automatic tap(input tecs_axis_t ax, input tecs_axis_t ng);
    @(posedge clk);
    ps <= ax;
    @(posedge clk);
    ps <= 3'h0;
    pe <= ax;
    pn <= ng;
    @(posedge clk);
    pe <= 3'h0;
    pn <= ~ng;
  endtask : tap
  task automatic conclude();
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    nrst = 1'b0;
    {ps, pe, pn} = 9'h000;
    lat = 8'h00;
    win = 8'h00;
    seed = 32'hfcc9;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    u_tecs_host.rd(`TECS_SETUP_ADDR, d);
    `CHK("setup_rst", 8'h00, d)
    u_tecs_host.rd(`TECS_STATUS_ADDR, d);
    `CHK("status_rst", 8'h00, d)
    `CHK("irq_rst", 1'b0, irq)
    for (i = 0; i < 8; i++) begin
      r = $random(seed);
      u_tecs_host.wr(`TECS_SETUP_ADDR, r[7:0]);
      u_tecs_host.wr(`TECS_STATUS_ADDR, ~r[7:0]);
      u_tecs_host.rd(`TECS_SETUP_ADDR, d);
      `CHK("setup_rw", r[7:0], d)
      u_tecs_host.rd(8'h20, d);
      `CHK("unmapped", 8'h00, d)
      u_tecs_host.rd(`TECS_STATUS_ADDR, d);
      `CHK("status_ro", 8'h00, d)
    end
    // Single taps; corner axis sets first, then random
    for (i = 0; i < 24; i++) begin
      r = $random(seed);
      cfg = {2'b00, r[5:0]};
      if (i < 3) cfg = 8'h15;
      lat = {6'h00, r[9:8]};
      win = {6'h00, r[11:10]};
      a = (i < 3) ? 3'(1 << i) : r[14:12];
      n = r[17:15];
      u_tecs_host.wr(`TECS_SETUP_ADDR, cfg);
      tap(a, n);
      repeat (2) @(posedge clk);
      #1;
      `CHK("irq_set", exp_st(a, n, cfg, 1'b0) != 8'h00, irq)
      u_tecs_host.rd(`TECS_STATUS_ADDR, d);
      `CHK("single", exp_st(a, n, cfg, 1'b0), d)
      `CHK("irq_clr", 1'b0, irq)
      u_tecs_host.rd(`TECS_STATUS_ADDR, d);
      `CHK("cleared", 8'h00, d)
      repeat (40) @(posedge clk);
    end
    // Double tap with latch off then on
    lat = 8'h00;
    win = 8'h05;
    for (p = 0; p < 2; p++) begin
      cfg = {1'b0, p[0], 6'h3f};
      u_tecs_host.wr(`TECS_SETUP_ADDR, cfg);
      tap(3'h3, 3'h1);
      repeat (4) @(posedge clk);
      tap(3'h6, 3'h6);
      repeat (3) @(posedge clk);
      u_tecs_host.rd(`TECS_STATUS_ADDR, d);
      `CHK("double", p ? exp_st(3'h3, 3'h1, cfg, 1'b0) : exp_st(3'h6, 3'h6, cfg, 1'b1), d)
      repeat (40) @(posedge clk);
    end
    // Pulse inside latency, abort off then on
    lat = 8'h07;
    win = 8'h07;
    for (p = 0; p < 2; p++) begin
      cfg = {p[0], 7'h3f};
      u_tecs_host.wr(`TECS_SETUP_ADDR, cfg);
      tap(3'h1, 3'h0);
      tap(3'h2, 3'h2);
      repeat (18) @(posedge clk);
      tap(3'h4, 3'h4);
      repeat (3) @(posedge clk);
      u_tecs_host.rd(`TECS_STATUS_ADDR, d);
      `CHK("abort", exp_st(3'h4, 3'h4, cfg, p == 0), d)
      repeat (40) @(posedge clk);
    end
    // Reset in mid-run while a latched tap is pending
    u_tecs_host.wr(`TECS_SETUP_ADDR, 8'h7f);
    tap(3'h5, 3'h4);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq_pre", 1'b1, irq)
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    `CHK("irq_rst2", 1'b0, irq)
    u_tecs_host.rd(`TECS_SETUP_ADDR, d);
    `CHK("setup_rst2", 8'h00, d)
    u_tecs_host.rd(`TECS_STATUS_ADDR, d);
    `CHK("status_rst2", 8'h00, d)
    conclude();
  end
endmodule : test_tecs_top
